// ==== hw/fscr_pkg.sv ====
package fscr_pkg;
	// Register locations on the link
	localparam logic [7:0] ADDR_CTRL = 8'h01;
	localparam logic [7:0] ADDR_FAULT = 8'h08;
	localparam logic [7:0] ADDR_RSV_LO = 8'h09;
	localparam logic [7:0] ADDR_RSV_HI = 8'h0f;
	localparam logic [7:0] ADDR_CLIP_MID = 8'h10;
	localparam logic [7:0] ADDR_CLIP_LOW = 8'h11;
	// Field positions
	localparam int CTRL_SD_BIT = 0;
	localparam int FLT_CLK_BIT = 3;
	localparam int FLT_OC_BIT = 2;
	localparam int FLT_DC_BIT = 1;
	localparam int FLT_OT_BIT = 0;
	localparam int OC_SEL_LSB = 4;
	localparam int CLIP_LOW_LSB = 2;
	localparam int CLIP_W = 20;
	localparam int CLIP_UPPER_W = 6;
	// Reset values and reserved masks
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] OC_SEL_RST = 2'h0;
	localparam logic [7:0] CLIP_MID_RST = 8'hff;
	localparam logic [7:0] CLIP_LOW_RST = 8'hfc;
	localparam logic [7:0] FAULT_RSV_MASK = 8'hc0;
	localparam logic [7:0] FAULT_RSV_VAL = 8'h00;
	localparam logic [7:0] CLIP_LOW_RSV_MASK = 8'h03;
	localparam logic [7:0] CLIP_LOW_RSV_VAL = 8'h00;
	localparam logic [5:0] CLIP_UPPER_DEF = 6'h3f;
	// Overcurrent scaling codes
	localparam logic [1:0] OC_FULL = 2'h0;
	localparam logic [1:0] OC_75 = 2'h1;
	localparam logic [1:0] OC_50 = 2'h2;
	localparam logic [1:0] OC_25 = 2'h3;
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int CLK_STOP_NS = 10000;
	localparam int CLK_STOP_CYCLES = CLK_STOP_NS / CLK_PERIOD_NS;
	// Host side Avalon map, byte addresses
	localparam logic [4:0] AV_CMD = 5'h00;
	localparam logic [4:0] AV_STATUS = 5'h04;
	localparam logic [4:0] AV_IRQ_STAT = 5'h08;
	localparam logic [4:0] AV_IRQ_MASK = 5'h0c;
	localparam logic [4:0] AV_SHUTDOWN = 5'h10;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_WR_BIT = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DATA_LSB = 8;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_REFUSED_BIT = 1;
	localparam int IRQ_W = 2;
	typedef enum logic [2:0] {
		HST_IDLE = 3'b001,
		HST_ISSUE = 3'b010,
		HST_WAIT = 3'b100
	} fscr_host_state_e;
endpackage

// ==== hw/fscr_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface fscr_link_if;
	logic [7:0] regAddr;
	logic [7:0] regWdata;
	logic [7:0] regRdata;
	logic regWrite;
	logic regRead;
	logic regAck;
	logic speakerShutdownN;
	modport device(input regAddr, input regWdata, input regWrite, input regRead,
		input speakerShutdownN, output regRdata, output regAck);
	modport host(output regAddr, output regWdata, output regWrite, output regRead,
		output speakerShutdownN, input regRdata, input regAck);
endinterface
`default_nettype wire

// ==== hw/fscr_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module fscr_device #(
	parameter int SAMPLE_W = 24,
	parameter int CUR_W = 12,
	parameter logic [11:0] OC_NOMINAL = 12'h800,
	parameter logic [11:0] DC_LIMIT = 12'h100,
	parameter int CLK_STOP_LIMIT = fscr_pkg::CLK_STOP_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	fscr_link_if.device link,
	input wire logic bitClock,
	input wire logic [CUR_W-1:0] outputCurrent,
	input wire logic [CUR_W-1:0] outputOffset,
	input wire logic dieOverTemp,
	input wire logic sampleValid,
	input wire logic signed [SAMPLE_W-1:0] sampleIn,
	output logic signed [SAMPLE_W-1:0] sampleOut,
	output logic sampleOutValid,
	output logic running
);
	function automatic logic [CUR_W-1:0] scaleTrip(input logic [1:0] code);
		logic [CUR_W-1:0] nom;
		nom = OC_NOMINAL[CUR_W-1:0];
		unique case (code)
			fscr_pkg::OC_FULL: scaleTrip = nom;
			fscr_pkg::OC_75: scaleTrip = nom - (nom >> 2);
			fscr_pkg::OC_50: scaleTrip = nom >> 1;
			fscr_pkg::OC_25: scaleTrip = nom >> 2;
		endcase
	endfunction

	logic [7:0] ctrl_reg;
	logic [1:0] ocSel_reg;
	logic [7:0] clipMid_reg;
	logic [7:0] clipLow_reg;
	// Latched faults sit at their own fault register bit positions
	wire logic [fscr_pkg::FLT_OC_BIT:fscr_pkg::FLT_OT_BIT] faultEvent;
	wire logic [fscr_pkg::FLT_OC_BIT:fscr_pkg::FLT_OT_BIT] faultLatched;
	logic clkErr_reg;
	logic bitClockPrev_reg;
	logic [$clog2(CLK_STOP_LIMIT+1)-1:0] stopCount_reg;
	logic [7:0] rdata_reg;
	logic ack_reg;
	logic signed [SAMPLE_W-1:0] sampleOut_reg;
	logic sampleOutValid_reg;

	// Shutdown is the OR of both paths; either one can clear latched faults
	wire logic shutdownActive = !link.speakerShutdownN || !ctrl_reg[fscr_pkg::CTRL_SD_BIT];
	wire logic [CUR_W-1:0] ocTrip = scaleTrip(ocSel_reg);
	wire logic ocEvent = outputCurrent > ocTrip;
	wire logic dcEvent = outputOffset > DC_LIMIT[CUR_W-1:0];
	assign faultEvent[fscr_pkg::FLT_OC_BIT] = ocEvent;
	assign faultEvent[fscr_pkg::FLT_DC_BIT] = dcEvent;
	// Temperature has no threshold here; the sensor flag itself is the event
	assign faultEvent[fscr_pkg::FLT_OT_BIT] = dieOverTemp;
	wire logic overcurrentError = faultLatched[fscr_pkg::FLT_OC_BIT];
	wire logic outputOffsetError = faultLatched[fscr_pkg::FLT_DC_BIT];
	wire logic overTempError = faultLatched[fscr_pkg::FLT_OT_BIT];
	wire logic bitClockEdge = bitClock != bitClockPrev_reg;
	wire logic clkStopped = stopCount_reg == ($bits(stopCount_reg))'(CLK_STOP_LIMIT);
	wire logic [fscr_pkg::CLIP_W-1:0] clipThresholdLevel = {fscr_pkg::CLIP_UPPER_DEF,
		clipMid_reg, clipLow_reg[7:fscr_pkg::CLIP_LOW_LSB]};
	// Negative bound mirrors the positive one, so both excursions clip alike
	wire logic signed [SAMPLE_W-1:0] clipPos = SAMPLE_W'(clipThresholdLevel);
	wire logic signed [SAMPLE_W-1:0] clipNeg = -clipPos;
	wire logic signed [SAMPLE_W-1:0] clipped = (sampleIn > clipPos) ? clipPos :
		(sampleIn < clipNeg) ? clipNeg : sampleIn;
	// Clock error halts output but recovers on its own
	wire logic runNow = !shutdownActive && !overcurrentError && !outputOffsetError
		&& !overTempError && !clkErr_reg;
	// Reserved fault register bits always read back as their default
	logic [7:0] faultView;
	always_comb begin
		faultView = fscr_pkg::FAULT_RSV_VAL;
		faultView[fscr_pkg::OC_SEL_LSB +: 2] = ocSel_reg;
		faultView[fscr_pkg::FLT_CLK_BIT] = clkErr_reg;
		faultView[fscr_pkg::FLT_OC_BIT:fscr_pkg::FLT_OT_BIT] = faultLatched;
	end
	wire logic [7:0] rdMux =
		(link.regAddr == fscr_pkg::ADDR_CTRL) ? ctrl_reg :
		(link.regAddr == fscr_pkg::ADDR_FAULT) ? faultView :
		(link.regAddr == fscr_pkg::ADDR_CLIP_MID) ? clipMid_reg :
		(link.regAddr == fscr_pkg::ADDR_CLIP_LOW) ? clipLow_reg : 8'h00;
	wire logic wrCtrl = link.regWrite && link.regAddr == fscr_pkg::ADDR_CTRL;
	wire logic wrFault = link.regWrite && link.regAddr == fscr_pkg::ADDR_FAULT;
	wire logic wrMid = link.regWrite && link.regAddr == fscr_pkg::ADDR_CLIP_MID;
	wire logic wrLow = link.regWrite && link.regAddr == fscr_pkg::ADDR_CLIP_LOW;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= fscr_pkg::CTRL_RST;
		end else begin
			if (wrCtrl) begin
				ctrl_reg <= link.regWdata;
			end
		end
	end

	// Only the scaling field of the fault register is writable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ocSel_reg <= fscr_pkg::OC_SEL_RST;
		end else begin
			if (wrFault) begin
				ocSel_reg <= link.regWdata[fscr_pkg::OC_SEL_LSB +: 2];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clipMid_reg <= fscr_pkg::CLIP_MID_RST;
		end else begin
			if (wrMid) begin
				clipMid_reg <= link.regWdata;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clipLow_reg <= fscr_pkg::CLIP_LOW_RST;
		end else begin
			if (wrLow) begin
				clipLow_reg <= link.regWdata;
			end
		end
	end

	// Faults clear only in shutdown; a condition still present wins over the clear
	for (genvar g = fscr_pkg::FLT_OT_BIT; g <= fscr_pkg::FLT_OC_BIT; g++) begin : faultLatch
		logic held_reg;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				held_reg <= 1'b0;
			end else begin
				held_reg <= faultEvent[g] || (held_reg && !shutdownActive);
			end
		end
		assign faultLatched[g] = held_reg;
	end

	// A stalled bit clock is seen only after the stop window; shorter gaps are tolerated
	// The counter stops at the limit so a long stall never wraps back to valid
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bitClockPrev_reg <= 1'b0;
			stopCount_reg <= '0;
			clkErr_reg <= 1'b0;
		end else begin
			bitClockPrev_reg <= bitClock;
			if (bitClockEdge) begin
				stopCount_reg <= '0;
			end else if (!clkStopped) begin
				stopCount_reg <= stopCount_reg + 1'b1;
			end
			clkErr_reg <= clkStopped && !bitClockEdge;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= link.regWrite || link.regRead;
			if (link.regRead) begin
				rdata_reg <= rdMux;
			end
		end
	end

	// A sample arriving while halted is output as zero rather than the last sample
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sampleOut_reg <= '0;
			sampleOutValid_reg <= 1'b0;
		end else begin
			sampleOutValid_reg <= sampleValid && runNow;
			if (sampleValid) begin
				sampleOut_reg <= runNow ? clipped : '0;
			end
		end
	end

	assign link.regRdata = rdata_reg;
	assign link.regAck = ack_reg;
	assign sampleOut = sampleOut_reg;
	assign sampleOutValid = sampleOutValid_reg;
	assign running = runNow;
endmodule
`default_nettype wire

// ==== hw/fscr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module fscr_host (
	input wire logic clk,
	input wire logic rst_n,
	fscr_link_if.host link,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq
);
	fscr_pkg::fscr_host_state_e state_reg;
	logic [7:0] addr_reg;
	logic [7:0] wdata_reg;
	logic isWrite_reg;
	logic [7:0] rdata_reg;
	logic [fscr_pkg::IRQ_W-1:0] irqStat_reg;
	logic [fscr_pkg::IRQ_W-1:0] irqMask_reg;
	logic sdPin_reg;
	logic [31:0] avRdata_reg;
	logic rdReady_reg;

	wire logic busy = state_reg != fscr_pkg::HST_IDLE;
	wire logic cmdWr = avs_write && avs_address == fscr_pkg::AV_CMD;
	wire logic [7:0] cmdAddr = avs_writedata[7:0];
	wire logic [7:0] cmdData = avs_writedata[fscr_pkg::CMD_DATA_LSB +: 8];
	wire logic cmdRefused = cmdAddr >= fscr_pkg::ADDR_RSV_LO
		&& cmdAddr <= fscr_pkg::ADDR_RSV_HI;
	// Reserved bits are forced to their defaults before they reach the device
	wire logic [7:0] cmdSafe =
		(cmdAddr == fscr_pkg::ADDR_FAULT) ?
			((cmdData & ~fscr_pkg::FAULT_RSV_MASK) | fscr_pkg::FAULT_RSV_VAL) :
		(cmdAddr == fscr_pkg::ADDR_CLIP_LOW) ?
			((cmdData & ~fscr_pkg::CLIP_LOW_RSV_MASK) | fscr_pkg::CLIP_LOW_RSV_VAL) :
		cmdData;
	wire logic startCmd = cmdWr && !busy && !cmdRefused;
	wire logic refuseCmd = cmdWr && !busy && cmdRefused;
	wire logic doneEvt = state_reg == fscr_pkg::HST_WAIT && link.regAck;
	wire logic [fscr_pkg::IRQ_W-1:0] irqSet = {refuseCmd, doneEvt};
	wire logic [fscr_pkg::IRQ_W-1:0] irqClr = (avs_write && avs_address == fscr_pkg::AV_IRQ_STAT)
		? avs_writedata[fscr_pkg::IRQ_W-1:0] : '0;
	wire logic [31:0] avMux =
		(avs_address == fscr_pkg::AV_CMD) ?
			{15'h0000, isWrite_reg, wdata_reg, addr_reg} :
		(avs_address == fscr_pkg::AV_STATUS) ? {16'h0000, rdata_reg, 7'h00, busy} :
		(avs_address == fscr_pkg::AV_IRQ_STAT) ? {30'h00000000, irqStat_reg} :
		(avs_address == fscr_pkg::AV_IRQ_MASK) ? {30'h00000000, irqMask_reg} :
		(avs_address == fscr_pkg::AV_SHUTDOWN) ? {31'h00000000, sdPin_reg} : 32'h00000000;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= fscr_pkg::HST_IDLE;
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			isWrite_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			unique case (state_reg)
				fscr_pkg::HST_IDLE: begin
					if (startCmd) begin
						addr_reg <= cmdAddr;
						wdata_reg <= cmdSafe;
						isWrite_reg <= avs_writedata[fscr_pkg::CMD_WR_BIT];
						state_reg <= fscr_pkg::HST_ISSUE;
					end
				end
				fscr_pkg::HST_ISSUE: state_reg <= fscr_pkg::HST_WAIT;
				fscr_pkg::HST_WAIT: begin
					if (link.regAck) begin
						if (!isWrite_reg) begin
							rdata_reg <= link.regRdata;
						end
						state_reg <= fscr_pkg::HST_IDLE;
					end
				end
				default: state_reg <= fscr_pkg::HST_IDLE;
			endcase
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStat_reg <= '0;
			irqMask_reg <= '0;
			sdPin_reg <= 1'b0;
			avRdata_reg <= 32'h00000000;
			rdReady_reg <= 1'b0;
		end else begin
			irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
			if (avs_write && avs_address == fscr_pkg::AV_IRQ_MASK) begin
				irqMask_reg <= avs_writedata[fscr_pkg::IRQ_W-1:0];
			end
			if (avs_write && avs_address == fscr_pkg::AV_SHUTDOWN) begin
				sdPin_reg <= avs_writedata[0];
			end
			rdReady_reg <= avs_read && !rdReady_reg;
			avRdata_reg <= avMux;
		end
	end

	assign link.regAddr = addr_reg;
	assign link.regWdata = wdata_reg;
	assign link.regWrite = state_reg == fscr_pkg::HST_ISSUE && isWrite_reg;
	assign link.regRead = state_reg == fscr_pkg::HST_ISSUE && !isWrite_reg;
	assign link.speakerShutdownN = sdPin_reg;
	assign avs_readdata = avRdata_reg;
	assign avs_waitrequest = avs_read && !rdReady_reg;
	assign irq = |(irqStat_reg & irqMask_reg);
endmodule
`default_nettype wire

// ==== bench/fscr_link_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module fscr_link_assertions (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic regAck,
	input wire logic speakerShutdownN
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic stb = regWrite | regRead;
	wire logic atFault = regAddr == fscr_pkg::ADDR_FAULT;
	property p_ack; stb |=> regAck; endproperty
	a_ack: assert property (p_ack) else $error("strobe not answered");
	property p_ackOnce; regAck |=> !regAck; endproperty
	a_ackOnce: assert property (p_ackOnce) else $error("ack longer than one cycle");
	property p_noStray; regAck |-> $past(stb); endproperty
	a_noStray: assert property (p_noStray) else $error("ack without strobe");
	// Host waits for the ack, so strobes never come back to back
	property p_spacing; stb |=> !stb; endproperty
	a_spacing: assert property (p_spacing) else $error("strobes too close");
	property p_excl; !(regWrite && regRead); endproperty
	a_excl: assert property (p_excl) else $error("read and write together");
	property p_rsvAddr; stb |-> !(regAddr inside {[8'h09:8'h0f]}); endproperty
	a_rsvAddr: assert property (p_rsvAddr) else $error("reserved location used");
	property p_faultW; regWrite && atFault |-> regWdata[7:6] == 2'h0; endproperty
	a_faultW: assert property (p_faultW) else $error("fault reserved bits written");
	property p_faultR; regRead && atFault |=> regRdata[7:6] == 2'h0; endproperty
	a_faultR: assert property (p_faultR) else $error("fault reserved bits not zero");
	property p_clipLow;
		regWrite && regAddr == fscr_pkg::ADDR_CLIP_LOW |-> regWdata[1:0] == 2'h0;
	endproperty
	a_clipLow: assert property (p_clipLow) else $error("clip low reserved bits written");
	property p_hold; !regRead |=> $stable(regRdata); endproperty
	a_hold: assert property (p_hold) else $error("read data changed without read");
endmodule
`default_nettype wire

// ==== bench/fault_status_clip_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module fault_status_clip_regs_bench;
	logic clk = 1'b0, rst_n = 1'b0, bitClock = 1'b0, bclkRun = 1'b1, dieOverTemp = 1'b0;
	logic sampleValid = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic [11:0] outputCurrent = 12'h000, outputOffset = 12'h000, trip;
	logic signed [23:0] sampleIn = 24'sh0, sampleOut;
	logic sampleOutValid, running, avs_waitrequest, irq;
	logic [3:0] expBits;
	int fails = 0, numChecks = 0, cyc = 0;
	// Rows: location, write data, read back
	logic [23:0] rows [5] = '{24'h10a5a5, 24'h115e5c, 24'h08f030, 24'h010101, 24'h207700};
	// Rows: sample in, sample out, threshold 0x0fd6a1
	logic [47:0] clipRows [4] = '{{24'h7fffff, 24'h0fd6a1}, {24'h800000, 24'hf0295f},
		{24'h0fd6a2, 24'h0fd6a1}, {24'hf0295f, 24'hf0295f}};
	fscr_link_if link();
	fscr_device #(.CLK_STOP_LIMIT(8)) fscr_device_inst (.clk(clk), .rst_n(rst_n), .link(link),
		.bitClock(bitClock), .outputCurrent(outputCurrent), .outputOffset(outputOffset),
		.dieOverTemp(dieOverTemp), .sampleValid(sampleValid), .sampleIn(sampleIn),
		.sampleOut(sampleOut), .sampleOutValid(sampleOutValid), .running(running));
	fscr_host fscr_host_inst (.clk(clk), .rst_n(rst_n), .link(link), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
	fscr_link_assertions fscr_link_assertions_inst (.clk(clk), .rst_n(rst_n),
		.regAddr(link.regAddr), .regWdata(link.regWdata), .regRdata(link.regRdata),
		.regWrite(link.regWrite), .regRead(link.regRead), .regAck(link.regAck),
		.speakerShutdownN(link.speakerShutdownN));
	initial forever #50 clk = ~clk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task finish_test();
		$display("checks %0d, mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (bclkRun) bitClock <= ~bitClock;
		if (link.regWrite | link.regRead) chk(link.regAddr inside {[8'h09:8'h0f]}, 0);
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
	end
	// Avalon transfer; request held until waitrequest is seen low
	task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		if (!wr) rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// One link access; leaves the link read data in rd[15:8], fault bits in rd[11:8]
	task lk(input logic wr, input logic [7:0] a, input logic [7:0] d);
		av(1'b1, fscr_pkg::AV_CMD, {15'h0, wr, d, a});
		do av(1'b0, fscr_pkg::AV_STATUS, 32'h0); while (rd[fscr_pkg::STAT_BUSY_BIT] !== 1'b0);
		av(1'b1, fscr_pkg::AV_IRQ_STAT, 32'h3);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		av(1'b1, fscr_pkg::AV_IRQ_MASK, 32'h3);
		av(1'b1, fscr_pkg::AV_SHUTDOWN, 32'h1);
		foreach (rows[r]) begin
			lk(1'b1, rows[r][23:16], rows[r][15:8]);
			lk(1'b0, rows[r][23:16], 8'h00);
			chk(rd[15:8], rows[r][7:0]);
		end
		$display("register rows done");
		// Codes 0..3 scale the overcurrent trip, then offset, then temperature
		for (int i = 0; i < 6; i++) begin
			trip = 12'h800 - 12'h200 * 12'(i);
			expBits = (i < 4) ? 4'h4 : ((i == 4) ? 4'h2 : 4'h1);
			if (i < 4) lk(1'b1, fscr_pkg::ADDR_FAULT, 8'(i * 16));
			for (int k = 0; k < 2; k++) begin
				outputCurrent <= (i < 4) ? trip + 12'(k) : 12'h0;
				outputOffset <= (i == 4) ? 12'h100 + 12'(k) : 12'h0;
				dieOverTemp <= (i == 5) && k;
				lk(1'b0, fscr_pkg::ADDR_FAULT, 8'h00);
				chk(rd[11:8], k ? expBits : 4'h0);
			end
			outputCurrent <= 12'h0;
			outputOffset <= 12'h0;
			dieOverTemp <= 1'b0;
			lk(1'b0, fscr_pkg::ADDR_FAULT, 8'h00);
			chk({rd[11:8], running}, {expBits, 1'b0});
			// Alternate pin and control bit to show both shutdown paths clear it
			if (i % 2 == 0) av(1'b1, fscr_pkg::AV_SHUTDOWN, 32'h0);
			else lk(1'b1, fscr_pkg::ADDR_CTRL, 8'h00);
			if (i % 2 == 0) av(1'b1, fscr_pkg::AV_SHUTDOWN, 32'h1);
			else lk(1'b1, fscr_pkg::ADDR_CTRL, 8'h01);
			lk(1'b0, fscr_pkg::ADDR_FAULT, 8'h00);
			chk({rd[11:8], running}, 5'h01);
		end
		$display("fault latching done");
		bclkRun <= 1'b0;
		repeat (12) @(posedge clk);
		lk(1'b0, fscr_pkg::ADDR_FAULT, 8'h00);
		chk({rd[11:8], running}, 5'h10);
		bclkRun <= 1'b1;
		lk(1'b0, fscr_pkg::ADDR_FAULT, 8'h00);
		chk({rd[11:8], running}, 5'h01);
		$display("clock error done");
		lk(1'b1, fscr_pkg::ADDR_CLIP_MID, 8'h5a);
		lk(1'b1, fscr_pkg::ADDR_CLIP_LOW, 8'h84);
		foreach (clipRows[j]) begin
			@(posedge clk);
			sampleValid <= 1'b1;
			sampleIn <= clipRows[j][47:24];
			@(posedge clk);
			sampleValid <= 1'b0;
			#1 chk({sampleOutValid, sampleOut}, {1'b1, clipRows[j][23:0]});
		end
		// A sample taken while shut down gives no valid output and a zero word
		av(1'b1, fscr_pkg::AV_SHUTDOWN, 32'h0);
		@(posedge clk);
		sampleValid <= 1'b1;
		sampleIn <= 24'sh000123;
		@(posedge clk);
		sampleValid <= 1'b0;
		#1 chk({sampleOutValid, sampleOut}, 25'h0);
		av(1'b1, fscr_pkg::AV_SHUTDOWN, 32'h1);
		$display("clipper done");
		// Refused command to a reserved location raises the interrupt without link traffic
		av(1'b1, fscr_pkg::AV_CMD, 32'h00000009);
		repeat (3) @(posedge clk);
		av(1'b0, fscr_pkg::AV_IRQ_STAT, 32'h0);
		chk({rd[fscr_pkg::IRQ_REFUSED_BIT], irq}, 2'h3);
		av(1'b1, fscr_pkg::AV_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		av(1'b1, fscr_pkg::AV_IRQ_STAT, 32'h3);
		av(1'b1, fscr_pkg::AV_IRQ_MASK, 32'h3);
		av(1'b0, fscr_pkg::AV_IRQ_STAT, 32'h0);
		chk({rd[1:0], irq}, 3'h0);
		av(1'b0, 5'h1c, 32'h0);
		chk(rd, 32'h0);
		$display("interrupt done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		chk(irq, 1'b0);
		lk(1'b0, fscr_pkg::ADDR_FAULT, 8'h00);
		chk(rd[15:8], 8'h00);
		lk(1'b0, fscr_pkg::ADDR_CLIP_MID, 8'h00);
		chk(rd[15:8], 8'hff);
		lk(1'b0, fscr_pkg::ADDR_CLIP_LOW, 8'h00);
		chk(rd[15:8], 8'hfc);
		lk(1'b0, fscr_pkg::ADDR_CTRL, 8'h00);
		chk(rd[15:8], 8'h00);
		$display("reset done");
		finish_test();
	end
endmodule
`default_nettype wire
